// ---- common/cps_pkg.sv ----
// Purpose: Shared constants and types of the converter protection supervisor
// Assumes: 10 MHz core clock, comparator results synchronous to it
// Notes:   Filter times are kept in microseconds, cycle counts derive from them; the restart pause is in cycles

package cps_pkg;

  // Clock rate
  localparam int unsigned CLK_MHZ = 10;

  // Boost overvoltage filter: level must hold this long before stop
  localparam int unsigned BOOST_OVP_US = 100;
  localparam logic [9:0]  BOOST_OVP_CYC = 10'(BOOST_OVP_US * CLK_MHZ);

  // Output overvoltage filter: switching cycles and least delay
  localparam logic [3:0]  OVP_CYCLES = 4'h000b;
  localparam int unsigned OVP_MIN_US = 75;
  localparam logic [9:0]  OVP_MIN_CYC = 10'(OVP_MIN_US * CLK_MHZ);

  // Thermistor low readings in a row that trip the external protection
  localparam logic [2:0]  NTC_LOW_COUNT = 3'h0004;

  // Pause before a safe restart recharges the supply
  localparam logic [8:0]  RESTART_CYC = 9'h01f4;

  // Widths
  localparam int unsigned BOOST_TMR_W = 10;
  localparam int unsigned OVP_TMR_W = 10;
  localparam int unsigned RESTART_W = 9;

  // Supervisor states
  typedef enum logic [2:0] {
    CPS_OFF     = 3'b000,
    CPS_RUN     = 3'b001,
    CPS_PROTECT = 3'b010,
    CPS_RESTART = 3'b011
  } cps_state_e;

endpackage : cps_pkg

// ---- logic/cps_ovp_filter.sv ----
// Purpose: Output overvoltage filter counting high switching cycles
// Assumes: cycle_end pulses once per half-bridge switching cycle
// Notes:   Trip needs both the cycle count and the least delay time

`timescale 1ns/1ns

module cps_ovp_filter
  import cps_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  // Sense
  input  wire logic enable,
  input  wire logic cycle_end,
  input  wire logic out_high,
  // Result
  output logic      trip
);

  typedef struct packed {
    logic [3:0]           cnt;
    logic [OVP_TMR_W-1:0] tmr;
    logic                 trip;
  } cps_ovp_s;

  cps_ovp_s st;
  cps_ovp_s next_st;

  // Count high cycles, time from the first one
  always_comb begin
    next_st = st;
    if (!enable) begin
      next_st = '0;
    end else begin
      if (st.cnt != 4'h0000 && st.tmr != OVP_MIN_CYC) begin
        next_st.tmr = st.tmr + 10'h0001;
      end
      if (cycle_end) begin
        if (!out_high) begin
          next_st.cnt = 4'h0000;
          next_st.tmr = '0;
        end else if (st.cnt != OVP_CYCLES) begin
          next_st.cnt = st.cnt + 4'h0001;
        end
      end
      // Jitter of one cycle comes from sampling on cycle_end only
      next_st.trip = (next_st.cnt == OVP_CYCLES) && (next_st.tmr == OVP_MIN_CYC);
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign trip = st.trip;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Low cycle empties the counter
  a_ovp_low_clear: assert property (ce && enable && cycle_end && !out_high |=> st.cnt == 4'h0000)
    else $error("ovp counter not cleared by low cycle");

  // Trip only after eleven cycles and the least delay
  a_ovp_trip_cause: assert property ($rose(st.trip) |-> $past(ce) && st.cnt == OVP_CYCLES
    && st.tmr == OVP_MIN_CYC)
    else $error("ovp trip without full count and delay");

  // No trip while disabled
  a_ovp_off_idle: assert property (ce && !enable |=> !st.trip && st.cnt == 4'h0000)
    else $error("ovp filter active while disabled");

endmodule : cps_ovp_filter

// ---- logic/cps_supervisor.sv ----
// Purpose: Protection supervisor for a PFC plus half-bridge converter
// Assumes: Every comparator input is a level synchronous to clk
// Notes:   Deep supply collapse resets the supervisor register except the system reset flag, which it sets; the overvoltage filter clears one cycle later

`timescale 1ns/1ns

// Function
// - Halt below 9 V, reset at 3.5 V
// - Burst idle: startup source regulates 14-14.9 V
// - Temperature faults latch, or restart safely
// - Boost sense above 2 V clears latch
// - Above 150 C stop PFC, pull boost low
// - Mains pin alternates mains and thermistor halves
// - Source 200 uA; four low readings trip
// - Brownin at 5.75 uA, brownout at 5 uA
// - Boost over 2.63 V 100 us stops PFC
// - PFC waits for boost above 0.5 V
// - Current sense 0.5 V ends PFC pulse
// - Start 19.1 V, 0.7 V hysteresis, stop 13.2 V
// - Half-bridge needs 11 V regulated, stops 9 V
// - High-side supply under 7 V stops driver
// - Half-bridge stops 1.6 V low-side, restarts 2.3 V
// - Output sense over 3.5 V stops, protects
// - About eleven high cycles trip overvoltage
// - Overvoltage delay at least 75 us
// - Output sense pin also sets burst rate
module cps_supervisor
  import cps_pkg::*;
(
  // Clock, reset, enable
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  // Variant strap: high selects safe restart instead of latching
  input  wire logic safe_restart_sel,
  // IC supply comparators
  input  wire logic ic_supply_above_19v1,
  input  wire logic ic_supply_below_18v4,
  input  wire logic ic_supply_above_14v9,
  input  wire logic ic_supply_below_14v,
  input  wire logic ic_supply_below_13v2,
  input  wire logic ic_supply_below_9v,
  input  wire logic ic_supply_below_3v5,
  // Regulated and high-side supply comparators
  input  wire logic regulated_supply_above_11v,
  input  wire logic regulated_supply_below_9v,
  input  wire logic high_side_supply_below_7v,
  // Mains sense
  input  wire logic mains_half_end,
  input  wire logic mains_above_5u75,
  input  wire logic mains_below_5u,
  input  wire logic mains_ntc_below_2v,
  // Boost sense comparators
  input  wire logic boost_above_2v63,
  input  wire logic boost_below_2v53,
  input  wire logic boost_above_2v3,
  input  wire logic boost_above_2v,
  input  wire logic boost_below_1v6,
  input  wire logic boost_above_0v5,
  // Current, temperature, output sense
  input  wire logic current_above_0v5,
  input  wire logic temp_above_150c,
  input  wire logic output_above_3v5,
  // Half-bridge timing from the switching logic
  input  wire logic hb_cycle_end,
  input  wire logic hb_low_side_on,
  input  wire logic burst_idle,
  // Supervisor outputs
  output logic      system_reset,
  output logic      high_voltage_startup_source_on,
  output logic      mains_ntc_mode,
  output logic      ntc_source_on,
  output logic      pfc_enable,
  output logic      pfc_gate_off,
  output logic      pfc_soft_start,
  output logic      hb_enable,
  output logic      hs_drive_enable,
  output logic      boost_pull_down,
  output logic      protect_latched,
  output logic      safe_restart
);

  typedef struct packed {
    cps_state_e             state;
    logic                   sys_rst;
    logic                   hv_on;
    logic                   mains_ntc;
    logic [2:0]             ntc_cnt;
    logic                   brown_ok;
    logic                   boost_ovp;
    logic [BOOST_TMR_W-1:0] boost_tmr;
    logic                   soft_start;
    logic                   reg_ok;
    logic                   hb_boost_ok;
    logic [RESTART_W-1:0]   restart_tmr;
    logic                   restart_pulse;
    logic                   pfc_en;
    logic                   hb_en;
    logic                   hs_en;
    logic                   pull_down;
  } cps_sup_s;

  cps_sup_s st;
  cps_sup_s next_st;

  logic ovp_trip;
  logic ext_otp;
  logic fault;
  logic latch_clear;

  // Output overvoltage filter, shared pin also sets burst rate externally
  cps_ovp_filter u_ovp (
    .clk       (clk),
    .rstn      (rstn),
    .ce        (ce),
    .enable    (st.hb_en),
    .cycle_end (hb_cycle_end),
    .out_high  (output_above_3v5),
    .trip      (ovp_trip)
  );

  // Fault sources and latch release
  assign ext_otp = st.mains_ntc && mains_half_end && mains_ntc_below_2v
                   && (st.ntc_cnt == NTC_LOW_COUNT - 3'h0001);
  assign fault = temp_above_150c || ext_otp || ovp_trip;
  // Supply or mains collapse, or a tester lifting boost sense, frees the latch
  assign latch_clear = ic_supply_below_9v || mains_below_5u || boost_above_2v;

  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.soft_start = 1'b0;
    next_st.restart_pulse = 1'b0;
    next_st.sys_rst = 1'b0;

    // Mains pin time sharing, one half-cycle each
    if (mains_half_end) begin
      next_st.mains_ntc = !st.mains_ntc;
      if (st.mains_ntc) begin
        if (!mains_ntc_below_2v || ext_otp) begin
          next_st.ntc_cnt = 3'h0000;
        end else begin
          next_st.ntc_cnt = st.ntc_cnt + 3'h0001;
        end
      end
    end

    // Brownin and brownout hysteresis
    if (mains_above_5u75) begin
      next_st.brown_ok = 1'b1;
    end else if (mains_below_5u) begin
      next_st.brown_ok = 1'b0;
    end

    // Boost overvoltage: filter the rise, release with soft start
    if (st.boost_ovp) begin
      next_st.boost_tmr = '0;
      if (boost_below_2v53) begin
        next_st.boost_ovp = 1'b0;
        next_st.soft_start = 1'b1;
      end
    end else if (boost_above_2v63) begin
      if (st.boost_tmr == BOOST_OVP_CYC) begin
        next_st.boost_ovp = 1'b1;
      end else begin
        next_st.boost_tmr = st.boost_tmr + 10'h0001;
      end
    end else begin
      next_st.boost_tmr = '0;
    end

    // Regulated supply window for the half-bridge
    if (regulated_supply_above_11v) begin
      next_st.reg_ok = 1'b1;
    end else if (regulated_supply_below_9v) begin
      next_st.reg_ok = 1'b0;
    end

    // Boost undervoltage only acts in a low-side phase
    if (boost_above_2v3) begin
      next_st.hb_boost_ok = 1'b1;
    end else if (boost_below_1v6 && hb_low_side_on) begin
      next_st.hb_boost_ok = 1'b0;
    end

    // Supervisor sequence
    case (st.state)
      CPS_OFF: begin
        next_st.hv_on = 1'b1;
        if (ic_supply_above_19v1) begin
          next_st.state = CPS_RUN;
          next_st.hv_on = 1'b0;
        end
      end
      CPS_RUN: begin
        if (burst_idle) begin
          // Keep supply up through long burst pauses
          if (ic_supply_below_14v) begin
            next_st.hv_on = 1'b1;
          end else if (ic_supply_above_14v9) begin
            next_st.hv_on = 1'b0;
          end
        end else if (!st.hb_en) begin
          // Fed by the startup source while not switching
          if (ic_supply_below_18v4) begin
            next_st.hv_on = 1'b1;
          end else if (ic_supply_above_19v1) begin
            next_st.hv_on = 1'b0;
          end
        end else begin
          next_st.hv_on = 1'b0;
        end
        if (ic_supply_below_13v2) begin
          next_st.state = CPS_OFF;
        end else if (fault) begin
          next_st.hv_on = 1'b0;
          next_st.restart_tmr = '0;
          next_st.state = safe_restart_sel ? CPS_RESTART : CPS_PROTECT;
        end
      end
      CPS_PROTECT: begin
        // Source stays off so the supply decays
        next_st.hv_on = 1'b0;
        if (latch_clear) begin
          next_st.state = CPS_OFF;
        end
      end
      CPS_RESTART: begin
        next_st.hv_on = 1'b0;
        if (st.restart_tmr == RESTART_CYC) begin
          next_st.state = CPS_OFF;
          next_st.restart_pulse = 1'b1;
        end else begin
          next_st.restart_tmr = st.restart_tmr + 9'h0001;
        end
      end
      default: begin
        next_st.state = CPS_OFF;
      end
    endcase

    // Supply undervoltage halts everything
    if (ic_supply_below_9v) begin
      next_st.state = CPS_OFF;
    end

    // Switch enables from the chosen next state
    next_st.pull_down = temp_above_150c;
    next_st.pfc_en = (next_st.state == CPS_RUN) && next_st.brown_ok && boost_above_0v5
                     && !next_st.boost_ovp && !temp_above_150c;
    next_st.hb_en = (next_st.state == CPS_RUN) && next_st.reg_ok && next_st.hb_boost_ok
                    && !temp_above_150c;
    next_st.hs_en = next_st.hb_en && !high_side_supply_below_7v;

    // Deep collapse: full system reset wins over all
    if (ic_supply_below_3v5) begin
      next_st = '0;
      next_st.sys_rst = 1'b1;
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // Outputs from flip-flops except the pulse-by-pulse current limit
  assign system_reset = st.sys_rst;
  assign high_voltage_startup_source_on = st.hv_on;
  assign mains_ntc_mode = st.mains_ntc;
  assign ntc_source_on = st.mains_ntc;
  assign pfc_enable = st.pfc_en;
  // Combinational so the switch opens within the present cycle
  assign pfc_gate_off = current_above_0v5 || !st.pfc_en;
  assign pfc_soft_start = st.soft_start;
  assign hb_enable = st.hb_en;
  assign hs_drive_enable = st.hs_en;
  assign boost_pull_down = st.pull_down;
  assign protect_latched = (st.state == CPS_PROTECT);
  assign safe_restart = st.restart_pulse;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_deep;
    ce && ic_supply_below_3v5;
  endsequence

  sequence s_alive;
    ce && !ic_supply_below_3v5;
  endsequence

  // Deep collapse resets, shallow one halts
  a_deep_reset_all: assert property (s_deep |=> system_reset && !pfc_enable && !hb_enable)
    else $error("no system reset at deep supply collapse");
  a_low_supply_halt: assert property (s_alive and ic_supply_below_9v |=> st.state == CPS_OFF
    && !pfc_enable)
    else $error("operation not halted below 9 V");

  // Burst idle recharge
  a_burst_hv_on: assert property (s_alive and st.state == CPS_RUN && burst_idle
    && ic_supply_below_14v && !ic_supply_below_13v2 && !fault |=> high_voltage_startup_source_on)
    else $error("startup source off in burst idle at 14 V");

  // Latch holds until a release cause
  a_latch_hold_fast: assert property (s_alive and st.state == CPS_PROTECT && !latch_clear
    |=> protect_latched)
    else $error("latched protection released without cause");
  a_tester_clear_latch: assert property (s_alive and st.state == CPS_PROTECT && boost_above_2v
    |=> !protect_latched)
    else $error("tester pull-up did not clear latch");

  // Overtemperature stops PFC and pulls boost low
  a_temp_stop_pfc: assert property (s_alive and temp_above_150c |=> boost_pull_down
    && !pfc_enable && !hb_enable)
    else $error("overtemperature did not stop converter");

  // Mains pin changes role each half-cycle
  a_mains_alternate: assert property (s_alive and mains_half_end
    |=> mains_ntc_mode != $past(mains_ntc_mode))
    else $error("mains sense role did not alternate");

  // External thermistor fault lands in protection, or in safe restart when selected
  a_ntc_trip_latch: assert property (s_alive and st.state == CPS_RUN && ext_otp
    && !ic_supply_below_9v && !ic_supply_below_13v2
    |=> st.state == (safe_restart_sel ? CPS_RESTART : CPS_PROTECT))
    else $error("thermistor fault not acted on");

  // Boost overvoltage needs the full filter time
  a_boost_ovp_time: assert property ($rose(st.boost_ovp) |-> $past(st.boost_tmr) == BOOST_OVP_CYC)
    else $error("boost overvoltage tripped early");
  a_boost_ovp_stop: assert property (st.boost_ovp |-> !pfc_enable)
    else $error("PFC running during boost overvoltage");

  // PFC waits for a live feedback loop
  a_scp_block: assert property (s_alive and !boost_above_0v5 |=> !pfc_enable)
    else $error("PFC enabled with boost sense under 0.5 V");

  // High-side driver needs its floating supply
  a_hs_uvp_stop: assert property (s_alive and high_side_supply_below_7v |=> !hs_drive_enable)
    else $error("high-side driver on below 7 V");

  // Output overvoltage trip ends switching
  a_out_ovp_stop: assert property (s_alive and ovp_trip && st.state == CPS_RUN
    && !ic_supply_below_13v2 && !ic_supply_below_9v |=> !hb_enable ##1 1'b1)
    else $error("output overvoltage did not stop switching");

endmodule : cps_supervisor

// ---- verif/cps_afe_model.sv ----
// Purpose: Analogue front end model, pin levels to comparator results
// Assumes: Bench changes levels just after the falling clock edge
// Notes:   A period of zero stops the matching timing pulse

`timescale 1ns/1ns

module cps_afe_model
  import cps_pkg::*;
(
  // Clock and thermistor source
  input  wire logic clk,
  input  wire logic ntc_source_on,
  // Pin levels in mV, mains current in nA, pulse periods in cycles
  input  var int    ic_mv,
  input  var int    reg_mv,
  input  var int    hs_mv,
  input  var int    boost_mv,
  input  var int    out_mv,
  input  var int    ntc_mv,
  input  var int    mains_na,
  input  var int    hb_per,
  input  var int    mains_per,
  // Supply comparators
  output logic      ic_supply_above_19v1,
  output logic      ic_supply_below_18v4,
  output logic      ic_supply_above_14v9,
  output logic      ic_supply_below_14v,
  output logic      ic_supply_below_13v2,
  output logic      ic_supply_below_9v,
  output logic      ic_supply_below_3v5,
  output logic      regulated_supply_above_11v,
  output logic      regulated_supply_below_9v,
  output logic      high_side_supply_below_7v,
  // Mains and thermistor sense
  output logic      mains_half_end,
  output logic      mains_above_5u75,
  output logic      mains_below_5u,
  output logic      mains_ntc_below_2v,
  // Boost and output sense
  output logic      boost_above_2v63,
  output logic      boost_below_2v53,
  output logic      boost_above_2v3,
  output logic      boost_above_2v,
  output logic      boost_below_1v6,
  output logic      boost_above_0v5,
  output logic      output_above_3v5,
  output logic      hb_cycle_end
);
  int   hb_n = 0;
  int   mn_n = 0;
  logic flip = 1'b0;

  // Supply thresholds
  assign ic_supply_above_19v1 = ic_mv >= 19100;
  assign ic_supply_below_18v4 = ic_mv < 18400;
  assign ic_supply_above_14v9 = ic_mv >= 14900;
  assign ic_supply_below_14v = ic_mv < 14000;
  assign ic_supply_below_13v2 = ic_mv < 13200;
  assign ic_supply_below_9v = ic_mv < 9000;
  assign ic_supply_below_3v5 = ic_mv < 3500;
  assign regulated_supply_above_11v = reg_mv >= 11000;
  assign regulated_supply_below_9v = reg_mv < 9000;
  assign high_side_supply_below_7v = hs_mv < 7000;
  // Mains and boost thresholds
  assign mains_above_5u75 = mains_na >= 5750;
  assign mains_below_5u = mains_na < 5000;
  assign boost_above_2v63 = boost_mv > 2630;
  assign boost_below_2v53 = boost_mv < 2530;
  assign boost_above_2v3 = boost_mv > 2300;
  assign boost_above_2v = boost_mv > 2000;
  assign boost_below_1v6 = boost_mv < 1600;
  assign boost_above_0v5 = boost_mv > 500;
  assign output_above_3v5 = out_mv > 3500;
  // No source current means no reading, so the level keeps shifting
  assign mains_ntc_below_2v = ntc_source_on ? (ntc_mv < 2000) : flip;

  // Timing pulses, one cycle wide; unknown only while reset is held
  always @(negedge clk) begin
    flip <= ~flip;
    hb_n <= (hb_n < hb_per - 1) ? hb_n + 1 : 0;
    mn_n <= (mn_n < mains_per - 1) ? mn_n + 1 : 0;
    hb_cycle_end <= (hb_per > 0) && (hb_n == hb_per - 1);
    mains_half_end <= (mains_per > 0) && (mn_n == mains_per - 1);
  end
endmodule : cps_afe_model

// ---- verif/tb.sv ----
// Purpose: Self-checking bench for the protection supervisor
// Assumes: Inputs change at the falling clock edge
// Notes:   Steady cases run from a table, timed faults by hand

`timescale 1ns/1ns

module tb
  import cps_pkg::*;
;
  typedef struct {
    int         ic, rg, hs, bo, mn;
    logic       cu, idle, low;
    logic [4:0] exp;
  } cps_row_s;

  // Expected {hv, pfc, gate_off, hb, hs_drive}
  cps_row_s rows [21] = '{
    '{15000, 12000, 12000, 400, 6000, 0, 0, 0, 5'h14},
    '{19500, 12000, 12000, 400, 6000, 0, 0, 0, 5'h04},
    '{19500, 12000, 12000, 2500, 6000, 0, 0, 0, 5'h0b},
    '{18000, 12000, 12000, 2500, 6000, 0, 0, 0, 5'h0b},
    '{18000, 12000, 12000, 2500, 6000, 1, 0, 0, 5'h0f},
    '{18000, 12000, 6000, 2500, 6000, 0, 0, 0, 5'h0a},
    '{13900, 12000, 12000, 2500, 6000, 0, 1, 0, 5'h1b},
    '{14500, 12000, 12000, 2500, 6000, 0, 1, 0, 5'h1b},
    '{15000, 12000, 12000, 2500, 6000, 0, 1, 0, 5'h0b},
    '{14500, 12000, 12000, 2500, 6000, 0, 1, 0, 5'h0b},
    '{14500, 12000, 12000, 2500, 5500, 0, 0, 0, 5'h0b},
    '{14500, 12000, 12000, 2500, 4900, 0, 0, 0, 5'h07},
    '{14500, 12000, 12000, 2500, 5800, 0, 0, 0, 5'h0b},
    '{14500, 12000, 12000, 1500, 5800, 0, 0, 0, 5'h0b},
    '{14500, 12000, 12000, 1500, 5800, 0, 0, 1, 5'h18},
    '{14500, 12000, 12000, 2500, 5800, 0, 0, 0, 5'h0b},
    '{14500, 8500, 12000, 2500, 5800, 0, 0, 0, 5'h18},
    '{14500, 10000, 12000, 2500, 5800, 0, 0, 0, 5'h18},
    '{14500, 12000, 12000, 2500, 5800, 0, 0, 0, 5'h0b},
    '{13000, 12000, 12000, 2500, 5800, 0, 0, 0, 5'h14},
    '{19500, 12000, 12000, 2500, 5800, 0, 0, 0, 5'h0b}};

  logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, safe_restart_sel = 1'b0, burst_idle = 1'b0;
  logic hb_low_side_on = 1'b0, current_above_0v5 = 1'b0, temp_above_150c = 1'b0;
  int   ic_mv = 15000, reg_mv = 12000, hs_mv = 12000, boost_mv = 400, out_mv = 1000;
  int   ntc_mv = 3000, mains_na = 6000, hb_per = 4, mains_per = 0;
  int   err_total = 0, checks_done = 0, cycles = 0, n;
  logic m;
  logic ic_supply_above_19v1, ic_supply_below_18v4, ic_supply_above_14v9, ic_supply_below_14v;
  logic ic_supply_below_13v2, ic_supply_below_9v, ic_supply_below_3v5, hb_cycle_end;
  logic regulated_supply_above_11v, regulated_supply_below_9v, high_side_supply_below_7v;
  logic mains_half_end, mains_above_5u75, mains_below_5u, mains_ntc_below_2v;
  logic boost_above_2v63, boost_below_2v53, boost_above_2v3, boost_above_2v;
  logic boost_below_1v6, boost_above_0v5, output_above_3v5;
  logic system_reset, high_voltage_startup_source_on, mains_ntc_mode, ntc_source_on, pfc_enable;
  logic pfc_gate_off, pfc_soft_start, hb_enable, hs_drive_enable, boost_pull_down;
  logic protect_latched, safe_restart;

  // Design and front end share net names
  cps_supervisor cps_supervisor_i (.*);
  cps_afe_model cps_afe_model_i (.*);

  always #50 clk = ~clk;

  // Hang guard, well above the longest sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  // Bounded wait for a one-cycle pulse; count comes back in cycles
  task automatic wait_hi(ref logic s, input int lim, output int k);
    k = 0;
    while (s !== 1'b1 && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask : wait_hi

  task automatic test_end(input string name);
    $display("test %s done at %0t ns", name, $time);
  endtask : test_end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    cyc(8);
    rstn = 1'b1;
    cyc(2);
    foreach (rows[i]) begin
      ic_mv = rows[i].ic;
      reg_mv = rows[i].rg;
      hs_mv = rows[i].hs;
      boost_mv = rows[i].bo;
      mains_na = rows[i].mn;
      current_above_0v5 = rows[i].cu;
      burst_idle = rows[i].idle;
      hb_low_side_on = rows[i].low;
      cyc(4);
      chk({high_voltage_startup_source_on, pfc_enable, pfc_gate_off, hb_enable, hs_drive_enable},
          rows[i].exp);
    end
    test_end("table");
    // Boost overvoltage must persist before switching stops
    boost_mv = 2700;
    cyc(990);
    chk(pfc_enable, 8'h01);
    cyc(20);
    chk(pfc_enable, 8'h00);
    boost_mv = 2580;
    cyc(10);
    chk(pfc_enable, 8'h00);
    boost_mv = 2500;
    wait_hi(pfc_soft_start, 20, n);
    chk(pfc_soft_start, 8'h01);
    cyc(3);
    chk(pfc_enable, 8'h01);
    test_end("boost_ovp");
    // Slow switching: cycle count decides the trip
    boost_mv = 1800;
    hb_per = 100;
    out_mv = 4000;
    cyc(900);
    chk(protect_latched, 8'h00);
    cyc(400);
    chk({protect_latched, hb_enable}, 8'h02);
    out_mv = 1000;
    boost_mv = 2500;
    cyc(3);
    chk(protect_latched, 8'h00);
    test_end("ovp_slow");
    // Fast switching with two low cycles: least delay restarts
    boost_mv = 1800;
    hb_per = 4;
    out_mv = 4000;
    cyc(20);
    out_mv = 1000;
    cyc(8);
    out_mv = 4000;
    cyc(740);
    chk(protect_latched, 8'h00);
    cyc(40);
    chk(protect_latched, 8'h01);
    out_mv = 1000;
    mains_na = 4900;
    cyc(3);
    chk(protect_latched, 8'h00);
    mains_na = 6000;
    cyc(3);
    test_end("ovp_fast");
    // Over-temperature latches and pulls boost sense down
    temp_above_150c = 1'b1;
    cyc(3);
    chk({boost_pull_down, pfc_enable, hb_enable, protect_latched}, 8'h09);
    temp_above_150c = 1'b0;
    ic_mv = 8000;
    cyc(3);
    chk(protect_latched, 8'h00);
    ic_mv = 19500;
    cyc(3);
    test_end("temp");
    // Thermistor halves and timed safe restart
    safe_restart_sel = 1'b1;
    mains_per = 20;
    cyc(25);
    m = mains_ntc_mode;
    cyc(20);
    chk(mains_ntc_mode, {7'h00, ~m});
    chk(ntc_source_on, {7'h00, ~m});
    ntc_mv = 1500;
    cyc(200);
    ntc_mv = 3000;
    wait_hi(safe_restart, 700, n);
    chk({n >= 400, safe_restart, protect_latched}, 8'h06);
    safe_restart_sel = 1'b0;
    mains_per = 0;
    cyc(5);
    test_end("ntc_restart");
    // Supply collapse halts, then resets the whole system
    // Enable low freezes state, so the halt waits for it
    ce = 1'b0;
    ic_mv = 8500;
    cyc(3);
    chk({pfc_enable, hb_enable}, 8'h03);
    ce = 1'b1;
    cyc(3);
    chk({pfc_enable, hb_enable, system_reset}, 8'h00);
    ic_mv = 3000;
    cyc(2);
    chk(system_reset, 8'h01);
    ic_mv = 15000;
    cyc(2);
    chk({system_reset, high_voltage_startup_source_on}, 8'h01);
    // Reset pin in mid-run clears the checked outputs except pfc_gate_off, which goes high
    ic_mv = 19500;
    cyc(3);
    rstn = 1'b0;
    cyc(2);
    chk({high_voltage_startup_source_on, pfc_enable, pfc_gate_off, hb_enable, protect_latched}, 8'h04);
    rstn = 1'b1;
    test_end("supply");
    stop_test();
  end
endmodule : tb
